// ==== hw/port_crossbar_assignment.sv ====
// port crossbar: priority pin allocation, skip logic, drive modes, memory bus ports
`timescale 1ns/1ps
`include "port_crossbar_defines.svh"

module port_crossbar_assignment (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic crossbarMasterEn,
	input wire logic serialZeroRouteEn,
	input wire logic twowireRouteEn,
	input wire logic serialOneRouteEn,
	input wire logic extIrqZeroRouteEn,
	input wire logic extIrqOneRouteEn,
	input wire logic memifLowPortEn,
	input wire logic memifPortSelect,
	input wire logic memifMuxModeBit,
	input wire logic [7:0] port0InputMode,
	input wire logic [7:0] port1InputMode,
	input wire logic [7:0] port0OutputMode,
	input wire logic [7:0] port1OutputMode,
	input wire logic [15:0] highOutputMode,
	input wire logic [15:0] lowLatch,
	input wire logic [15:0] highLatch,
	input wire logic serialZeroTx,
	input wire logic serialOneTx,
	input wire logic twowireSdaOut,
	input wire logic twowireSclOut,
	input wire logic memifAle,
	input wire logic memifRd_n,
	input wire logic memifWr_n,
	input wire logic externalDataMove,
	input wire logic [15:0] memifHighOut,
	input wire logic [15:0] memifHighOe,
	input wire logic [15:0] lowPinIn,
	input wire logic [15:0] highPinIn,
	output logic [15:0] lowPinOut,
	output logic [15:0] lowPinOe,
	output logic [15:0] highPinOut,
	output logic [15:0] highPinOe,
	output logic [15:0] lowPinState,
	output logic [15:0] highPinState,
	output logic serialZeroRx,
	output logic serialOneRx,
	output logic twowireSdaIn,
	output logic twowireSclIn,
	output logic extIrqZeroPin,
	output logic extIrqOnePin
);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic pinOe(input logic v, input logic pushPull);
		pinOe = pushPull | ~v;
	endfunction

	function automatic port_crossbar_pkg::sig_e sigOfIndex(input int i);
		unique case (i)
			0: sigOfIndex = port_crossbar_pkg::SIG_S0TX;
			1: sigOfIndex = port_crossbar_pkg::SIG_S0RX;
			2: sigOfIndex = port_crossbar_pkg::SIG_SDA;
			3: sigOfIndex = port_crossbar_pkg::SIG_SCL;
			4: sigOfIndex = port_crossbar_pkg::SIG_S1TX;
			5: sigOfIndex = port_crossbar_pkg::SIG_S1RX;
			6: sigOfIndex = port_crossbar_pkg::SIG_IRQ0;
			default: sigOfIndex = port_crossbar_pkg::SIG_IRQ1;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [15:0] lowSync1_reg, lowSync2_reg, highSync1_reg, highSync2_reg;
	logic [15:0] lowOut_next, lowOe_next, highOut_next, highOe_next;
	logic s0Rx_next, s1Rx_next, sdaIn_next, sclIn_next, irq0_next, irq1_next;
	port_crossbar_pkg::sig_e pinSig_reg [16];
	port_crossbar_pkg::sig_e pinSig_next [16];
	port_crossbar_pkg::sig_e sigList [8];
	logic [7:0] reqEn;
	logic [15:0] skipMask;
	logic [15:0] outMode;
	logic [3:0] sigCount, nextSlot;
	logic memifLow, memifMux, v;

	// ---------------------------------------------------------------
	// allocation
	// ---------------------------------------------------------------
	always_comb begin
		memifLow = crossbarMasterEn & memifLowPortEn;
		memifMux = memifLow & ~memifPortSelect & ~memifMuxModeBit;
		skipMask = ~{port1InputMode, port0InputMode};
		skipMask[`XB_RD_PIN] = skipMask[`XB_RD_PIN] | memifLow;
		skipMask[`XB_WR_PIN] = skipMask[`XB_WR_PIN] | memifLow;
		skipMask[`XB_ALE_PIN] = skipMask[`XB_ALE_PIN] | memifMux;
		// pairs share one enable, so tx/rx and data/clock stay adjacent
		reqEn = {extIrqOneRouteEn, extIrqZeroRouteEn, {2{serialOneRouteEn}},
			{2{twowireRouteEn}}, {2{serialZeroRouteEn}}};
		sigCount = `XB_ZERO_SLOT;
		for (int i = 0; i < `XB_SIGS; i++) begin
			sigList[i] = port_crossbar_pkg::SIG_NONE;
		end
		for (int i = 0; i < `XB_SIGS; i++) begin
			if (reqEn[i]) begin
				sigList[sigCount[2:0]] = sigOfIndex(i);
				sigCount = sigCount + 4'h1;
			end
		end
		nextSlot = `XB_ZERO_SLOT;
		for (int p = 0; p < `XB_LOW_PINS; p++) begin
			pinSig_next[p] = port_crossbar_pkg::SIG_NONE;
			// skipped pins pass the signal on to the next pin, across ports
			if (crossbarMasterEn && !skipMask[p] && nextSlot < sigCount) begin
				pinSig_next[p] = sigList[nextSlot[2:0]];
				nextSlot = nextSlot + 4'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// pin drive and peripheral inputs
	// ---------------------------------------------------------------
	always_comb begin
		outMode = {port1OutputMode, port0OutputMode};
		s0Rx_next = `XB_IDLE;
		s1Rx_next = `XB_IDLE;
		sdaIn_next = `XB_IDLE;
		sclIn_next = `XB_IDLE;
		irq0_next = `XB_IDLE;
		irq1_next = `XB_IDLE;
		v = `XB_IDLE;
		for (int p = 0; p < `XB_LOW_PINS; p++) begin
			v = lowLatch[p];
			unique case (pinSig_next[p])
				port_crossbar_pkg::SIG_NONE: v = lowLatch[p];
				port_crossbar_pkg::SIG_S0TX: v = serialZeroTx;
				port_crossbar_pkg::SIG_SDA: v = twowireSdaOut;
				port_crossbar_pkg::SIG_SCL: v = twowireSclOut;
				port_crossbar_pkg::SIG_S1TX: v = serialOneTx;
				port_crossbar_pkg::SIG_S0RX: s0Rx_next = lowSync2_reg[p];
				port_crossbar_pkg::SIG_S1RX: s1Rx_next = lowSync2_reg[p];
				port_crossbar_pkg::SIG_IRQ0: irq0_next = lowSync2_reg[p];
				port_crossbar_pkg::SIG_IRQ1: irq1_next = lowSync2_reg[p];
			endcase
			if (memifLow && p == `XB_RD_PIN) begin
				v = memifRd_n;
			end
			if (memifLow && p == `XB_WR_PIN) begin
				v = memifWr_n;
			end
			if (memifMux && p == `XB_ALE_PIN) begin
				v = memifAle;
			end
			if (pinSig_next[p] == port_crossbar_pkg::SIG_SDA) begin
				sdaIn_next = lowSync2_reg[p];
			end
			if (pinSig_next[p] == port_crossbar_pkg::SIG_SCL) begin
				sclIn_next = lowSync2_reg[p];
			end
			lowOut_next[p] = v;
			lowOe_next[p] = pinOe(v, outMode[p]);
			// input-only signals release their pin
			if (pinSig_next[p] inside {port_crossbar_pkg::SIG_S0RX, port_crossbar_pkg::SIG_S1RX,
				port_crossbar_pkg::SIG_IRQ0, port_crossbar_pkg::SIG_IRQ1}) begin
				lowOut_next[p] = `XB_IDLE;
				lowOe_next[p] = 1'b0;
			end
		end
		for (int p = 0; p < `XB_HIGH_PINS; p++) begin
			// memory bus drives ports two and three while externalDataMove is set, regardless of crossbar state
			highOut_next[p] = externalDataMove ? memifHighOut[p] : highLatch[p];
			highOe_next[p] = externalDataMove ? memifHighOe[p] :
				pinOe(highLatch[p], highOutputMode[p]);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			lowSync1_reg <= `XB_RST_OUT;
			lowSync2_reg <= `XB_RST_OUT;
			highSync1_reg <= `XB_RST_OUT;
			highSync2_reg <= `XB_RST_OUT;
			lowPinOut <= `XB_RST_OUT;
			lowPinOe <= `XB_RST_OE;
			highPinOut <= `XB_RST_OUT;
			highPinOe <= `XB_RST_OE;
			serialZeroRx <= `XB_IDLE;
			serialOneRx <= `XB_IDLE;
			twowireSdaIn <= `XB_IDLE;
			twowireSclIn <= `XB_IDLE;
			extIrqZeroPin <= `XB_IDLE;
			extIrqOnePin <= `XB_IDLE;
			for (int p = 0; p < `XB_LOW_PINS; p++) begin
				pinSig_reg[p] <= port_crossbar_pkg::SIG_NONE;
			end
		end else begin
			lowSync1_reg <= lowPinIn;
			lowSync2_reg <= lowSync1_reg;
			highSync1_reg <= highPinIn;
			highSync2_reg <= highSync1_reg;
			lowPinOut <= lowOut_next;
			lowPinOe <= lowOe_next;
			highPinOut <= highOut_next;
			highPinOe <= highOe_next;
			serialZeroRx <= s0Rx_next;
			serialOneRx <= s1Rx_next;
			twowireSdaIn <= sdaIn_next;
			twowireSclIn <= sclIn_next;
			extIrqZeroPin <= irq0_next;
			extIrqOnePin <= irq1_next;
			for (int p = 0; p < `XB_LOW_PINS; p++) begin
				pinSig_reg[p] <= pinSig_next[p];
			end
		end
	end

	assign lowPinState = lowSync2_reg;
	assign highPinState = highSync2_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	logic exampleCfg;
	assign exampleCfg = crossbarMasterEn & serialZeroRouteEn & twowireRouteEn & serialOneRouteEn
		& extIrqZeroRouteEn & extIrqOneRouteEn & memifLowPortEn & ~memifPortSelect
		& ~memifMuxModeBit & (port0InputMode == 8'hff) & (port1InputMode == 8'he3);

	priority_order_a: assert property (
		crossbarMasterEn && !serialZeroRouteEn && twowireRouteEn && port0InputMode[0]
		|=> pinSig_reg[0] == port_crossbar_pkg::SIG_SDA)
		else $error("twowire data not on first pin");
	serial_zero_a: assert property (
		crossbarMasterEn && serialZeroRouteEn && port0InputMode[0]
		|=> lowPinOut[0] == $past(serialZeroTx))
		else $error("serial zero tx not on first pin");
	twowire_pair_a: assert property (
		crossbarMasterEn && serialZeroRouteEn && twowireRouteEn
		&& (port0InputMode[3:0] == 4'hf) |=> pinSig_reg[2] == port_crossbar_pkg::SIG_SDA
		&& pinSig_reg[3] == port_crossbar_pkg::SIG_SCL)
		else $error("twowire pins misplaced");
	strobe_skip_a: assert property (
		crossbarMasterEn && memifLowPortEn
		|=> lowPinOut[`XB_WR_PIN] == $past(memifWr_n) && lowPinOut[`XB_RD_PIN] == $past(memifRd_n))
		else $error("memory strobes not on their pins");
	latch_skip_a: assert property (
		crossbarMasterEn && memifLowPortEn && !memifPortSelect
		&& !memifMuxModeBit |=> lowPinOut[`XB_ALE_PIN] == $past(memifAle)
		&& pinSig_reg[`XB_ALE_PIN] == port_crossbar_pkg::SIG_NONE)
		else $error("latch pin not skipped");
	example_map_a: assert property (
		exampleCfg |=> pinSig_reg[4] == port_crossbar_pkg::SIG_S1TX
		&& pinSig_reg[8] == port_crossbar_pkg::SIG_S1RX
		&& pinSig_reg[9] == port_crossbar_pkg::SIG_IRQ0
		&& pinSig_reg[10] == port_crossbar_pkg::SIG_NONE
		&& pinSig_reg[13] == port_crossbar_pkg::SIG_IRQ1)
		else $error("skip placement wrong");
	master_off_a: assert property (
		!crossbarMasterEn |=> lowPinOut == $past(lowLatch))
		else $error("pins not plain with master off");
	data_move_a: assert property (
		externalDataMove |=> highPinOut == $past(memifHighOut)
		&& highPinOe == $past(memifHighOe))
		else $error("memory bus not driving high ports");
	// an interrupt input landing on pin 0 releases it, so that case is left out
	push_pull_a: assert property (
		port0OutputMode[0] && (!crossbarMasterEn || !port0InputMode[0] || serialZeroRouteEn
		|| twowireRouteEn || serialOneRouteEn) |=> lowPinOe[0])
		else $error("push-pull pin not driven");
	release_od_a: assert property (
		!crossbarMasterEn && !port1OutputMode[2] && lowLatch[10]
		|=> !lowPinOe[10])
		else $error("open-drain one not released");

	example_cfg_c: cover property (exampleCfg ##1 exampleCfg);
	master_off_c: cover property (!crossbarMasterEn ##1 crossbarMasterEn);
	data_move_c: cover property (externalDataMove ##1 !externalDataMove);
	irq_input_c: cover property (pinSig_reg[13] == port_crossbar_pkg::SIG_IRQ1 && !extIrqOnePin);

endmodule

// ==== hw/port_crossbar_defines.svh ====
// constants for the port crossbar: pin positions, counts and reset levels
`ifndef PORT_CROSSBAR_DEFINES_SVH
`define PORT_CROSSBAR_DEFINES_SVH

`define XB_LOW_PINS 16
`define XB_HIGH_PINS 16
`define XB_SIGS 8
`define XB_ALE_PIN 5
`define XB_RD_PIN 6
`define XB_WR_PIN 7
`define XB_RST_OUT 16'hffff
`define XB_RST_OE 16'h0000
`define XB_RST_SIG 8'h00
`define XB_IDLE 1'b1
`define XB_ZERO_SLOT 4'h0

`endif

// ==== hw/port_crossbar_pkg.sv ====
// types shared by the port crossbar
package port_crossbar_pkg;

	typedef enum logic [3:0] {
		SIG_NONE,
		SIG_S0TX,
		SIG_S0RX,
		SIG_SDA,
		SIG_SCL,
		SIG_S1TX,
		SIG_S1RX,
		SIG_IRQ0,
		SIG_IRQ1
	} sig_e;

endpackage

// ==== bench/port_partner.sv ====
// devices wired to the port pins, every line with a pull-up
`timescale 1ns/1ps

module port_partner (
	input wire logic [15:0] lowPinOut,
	input wire logic [15:0] lowPinOe,
	input wire logic [15:0] highPinOut,
	input wire logic [15:0] highPinOe,
	input wire logic [31:0] extVal,
	input wire logic [31:0] extEn,
	output logic [31:0] pinLevel
);
	logic [31:0] oe;
	assign oe = {highPinOe, lowPinOe};
	// a released pin never keeps its old value: a device or the pull-up sets it
	assign pinLevel = (oe & {highPinOut, lowPinOut}) | (~oe & (~extEn | extVal));
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the port crossbar
`timescale 1ns/1ps

module tb_top;
	typedef struct {
		int cyc;
		logic [15:0] lo, loe, hi, hoe, ls, hs, rx;
	} note_s;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic crossbarMasterEn, serialZeroRouteEn, twowireRouteEn, serialOneRouteEn;
	logic extIrqZeroRouteEn, extIrqOneRouteEn, memifLowPortEn, memifPortSelect, memifMuxModeBit;
	logic serialZeroTx, serialOneTx, twowireSdaOut, twowireSclOut;
	logic memifAle, memifRd_n, memifWr_n, externalDataMove;
	logic [7:0] port0InputMode, port1InputMode, port0OutputMode, port1OutputMode;
	logic [15:0] highOutputMode, lowLatch, highLatch, memifHighOut, memifHighOe;
	logic [15:0] lowPinOut, lowPinOe, highPinOut, highPinOe, lowPinState, highPinState;
	logic serialZeroRx, serialOneRx, twowireSdaIn, twowireSclIn, extIrqZeroPin, extIrqOnePin;
	logic [31:0] extVal, extEn, pinLevel;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	note_s q[$];
	note_s e;
	logic [15:0] rxSeen;
	assign rxSeen = {10'h000, serialZeroRx, serialOneRx, twowireSdaIn, twowireSclIn,
		extIrqZeroPin, extIrqOnePin};

	always #5 ref_clk = ~ref_clk;

	port_crossbar_assignment port_crossbar_assignment_inst (
		.ref_clk(ref_clk), .reset(reset), .crossbarMasterEn(crossbarMasterEn),
		.serialZeroRouteEn(serialZeroRouteEn), .twowireRouteEn(twowireRouteEn),
		.serialOneRouteEn(serialOneRouteEn), .extIrqZeroRouteEn(extIrqZeroRouteEn),
		.extIrqOneRouteEn(extIrqOneRouteEn), .memifLowPortEn(memifLowPortEn),
		.memifPortSelect(memifPortSelect), .memifMuxModeBit(memifMuxModeBit),
		.port0InputMode(port0InputMode), .port1InputMode(port1InputMode),
		.port0OutputMode(port0OutputMode), .port1OutputMode(port1OutputMode),
		.highOutputMode(highOutputMode), .lowLatch(lowLatch), .highLatch(highLatch),
		.serialZeroTx(serialZeroTx), .serialOneTx(serialOneTx),
		.twowireSdaOut(twowireSdaOut), .twowireSclOut(twowireSclOut),
		.memifAle(memifAle), .memifRd_n(memifRd_n), .memifWr_n(memifWr_n),
		.externalDataMove(externalDataMove), .memifHighOut(memifHighOut),
		.memifHighOe(memifHighOe), .lowPinIn(pinLevel[15:0]), .highPinIn(pinLevel[31:16]),
		.lowPinOut(lowPinOut), .lowPinOe(lowPinOe), .highPinOut(highPinOut),
		.highPinOe(highPinOe), .lowPinState(lowPinState), .highPinState(highPinState),
		.serialZeroRx(serialZeroRx), .serialOneRx(serialOneRx), .twowireSdaIn(twowireSdaIn),
		.twowireSclIn(twowireSclIn), .extIrqZeroPin(extIrqZeroPin), .extIrqOnePin(extIrqOnePin)
	);

	port_partner port_partner_inst (
		.lowPinOut(lowPinOut), .lowPinOe(lowPinOe), .highPinOut(highPinOut),
		.highPinOe(highPinOe), .extVal(extVal), .extEn(extEn), .pinLevel(pinLevel)
	);

	// ----------------------------------------
	// expected pins, from inputs held for four edges
	// ----------------------------------------
	function automatic note_s expect_now();
		note_s n;
		port_crossbar_pkg::sig_e m [16];
		logic [8:1] en;
		logic [15:0] pp;
		logic [15:0] digi;
		logic [2:0] strobes;
		logic mux;
		logic o;
		int rxBit [9];
		int p;
		rxBit = '{-1, -1, 5, 3, 2, -1, 4, 1, 0};
		en = {extIrqOneRouteEn, extIrqZeroRouteEn, {2{serialOneRouteEn}}, {2{twowireRouteEn}},
			{2{serialZeroRouteEn}}};
		pp = {port1OutputMode, port0OutputMode};
		digi = {port1InputMode, port0InputMode};
		strobes = {memifWr_n, memifRd_n, memifAle};
		mux = memifLowPortEn && !memifPortSelect && !memifMuxModeBit;
		n.cyc = cyc + 4;
		n.rx = 16'h003f;
		p = 0;
		for (int i = 0; i < 16; i++) m[i] = port_crossbar_pkg::SIG_NONE;
		for (int k = 1; k < 9; k++) begin
			if (en[k] && crossbarMasterEn) begin
				while (p < 16 && (!digi[p] || (memifLowPortEn && (p == 6 || p == 7 || (p == 5 && mux)))))
					p++;
				if (p < 16) m[p] = port_crossbar_pkg::sig_e'(k);
				p++;
			end
		end
		for (int i = 0; i < 16; i++) begin
			o = lowLatch[i];
			if (crossbarMasterEn && memifLowPortEn && i > 4 && (i > 5 || mux) && i < 8) o = strobes[i-5];
			case (m[i])
				port_crossbar_pkg::SIG_S0TX: o = serialZeroTx;
				port_crossbar_pkg::SIG_SDA: o = twowireSdaOut;
				port_crossbar_pkg::SIG_SCL: o = twowireSclOut;
				port_crossbar_pkg::SIG_S1TX: o = serialOneTx;
				port_crossbar_pkg::SIG_NONE: ;
				default: o = 1'b1;
			endcase
			n.lo[i] = o;
			n.loe[i] = (9'h1c4 >> m[i]) & 9'h001 ? 1'b0 : pp[i] | ~o;
			n.ls[i] = n.loe[i] ? o : ~extEn[i] | extVal[i];
			if (rxBit[m[i]] >= 0) n.rx[rxBit[m[i]]] = n.ls[i];
		end
		n.hi = externalDataMove ? memifHighOut : highLatch;
		n.hoe = externalDataMove ? memifHighOe : highOutputMode | ~highLatch;
		n.hs = (n.hoe & n.hi) | (~n.hoe & (~extEn[31:16] | extVal[31:16]));
		if (reset) n = '{n.cyc, 16'hffff, 16'h0000, 16'hffff, 16'h0000, 16'hffff, 16'hffff, 16'h003f};
		return n;
	endfunction

	task automatic chk(logic [15:0] seen, logic [15:0] want);
		total_checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask

	task automatic rnd();
		{crossbarMasterEn, serialZeroRouteEn, twowireRouteEn, serialOneRouteEn, extIrqZeroRouteEn,
			extIrqOneRouteEn, memifLowPortEn, memifPortSelect, memifMuxModeBit} = 9'($urandom);
		{serialZeroTx, serialOneTx, twowireSdaOut, twowireSclOut, memifAle, memifRd_n, memifWr_n,
			externalDataMove} = 8'($urandom);
		{port0InputMode, port1InputMode, port0OutputMode, port1OutputMode} = $urandom;
		{highOutputMode, lowLatch} = $urandom;
		{highLatch, memifHighOut} = $urandom;
		memifHighOe = 16'($urandom);
		extVal = $urandom;
		extEn = $urandom;
	endtask

	task automatic go();
		q.push_back(expect_now());
		repeat (5) @(posedge ref_clk);
		#1;
	endtask

	task automatic complete_run();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// monitor and stimulus
	// ----------------------------------------
	initial forever begin
		@(posedge ref_clk);
		cyc++;
		#2;
		if (q.size() > 0 && q[0].cyc == cyc) begin
			e = q.pop_front();
			chk(lowPinOut, e.lo);
			chk(lowPinOe, e.loe);
			chk(highPinOut, e.hi);
			chk(highPinOe, e.hoe);
			chk(lowPinState, e.ls);
			chk(highPinState, e.hs);
			chk(rxSeen, e.rx);
		end
	end

	initial begin
		repeat (2000) @(posedge ref_clk);
		n_mismatch++;
		complete_run();
	end

	initial begin
		void'($urandom(32'h686f));
		rnd();
		go();
		reset = 1'b0;
		rnd();
		{crossbarMasterEn, serialZeroRouteEn, twowireRouteEn, serialOneRouteEn} = 4'hf;
		{extIrqZeroRouteEn, extIrqOneRouteEn, memifLowPortEn} = 3'h7;
		{memifPortSelect, memifMuxModeBit} = 2'h0;
		{port1InputMode, port0InputMode} = 16'he3ff;
		{port1OutputMode, port0OutputMode} = 16'h00f1;
		lowLatch[15:8] = 8'hff;
		go();
		memifMuxModeBit = 1'b1;
		go();
		crossbarMasterEn = 1'b0;
		go();
		for (int i = 0; i < 60; i++) begin
			rnd();
			reset = (i == 30);
			go();
		end
		if (q.size() != 0) n_mismatch++;
		complete_run();
	end
endmodule
